/* File: acc_pkg.sv */
`default_nettype none

package acc_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_IDX_FIRST_GAIN_LOW = 8'h0D;
    localparam logic [7:0] ACC_IDX_SECOND_SETUP = 8'h0E;
    localparam logic [7:0] ACC_IDX_SECOND_OFFSET_HIGH = 8'h0F;
    localparam logic [7:0] ACC_IDX_SECOND_OFFSET_LOW = 8'h10;
    localparam logic [7:0] ACC_IDX_SECOND_GAIN_HIGH = 8'h11;
    localparam logic [7:0] ACC_IDX_SECOND_GAIN_LOW = 8'h12;
    localparam int ACC_ADDR_W = 8;
    localparam int ACC_INDEX_W = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] ACC_RST_SETUP = 16'h0000;
    localparam logic [15:0] ACC_RST_OFFSET_HIGH = 16'h0000;
    localparam logic [15:0] ACC_RST_OFFSET_LOW = 16'h0000;
    localparam logic [15:0] ACC_RST_GAIN_HIGH = 16'h8000;
    localparam logic [15:0] ACC_RST_GAIN_LOW = 16'h0000;
    localparam logic [15:0] ACC_RST_FIRST_GAIN_LOW = 16'h0000;

    // ------------------------------------------------------------
    // writable bit masks; zero bits are reserved and read zero
    // ------------------------------------------------------------
    localparam logic [15:0] ACC_MASK_SETUP = 16'hFFC7;
    localparam logic [15:0] ACC_MASK_FULL = 16'hFFFF;
    localparam logic [15:0] ACC_MASK_UPPER_BYTE = 16'hFF00;

    // ------------------------------------------------------------
    // field positions of the setup register
    // ------------------------------------------------------------
    localparam int ACC_PHASE_MSB = 15;
    localparam int ACC_PHASE_LSB = 6;
    localparam int ACC_DC_OFF_BIT = 2;
    localparam int ACC_SEL_MSB = 1;
    localparam int ACC_SEL_LSB = 0;

    // ------------------------------------------------------------
    // input selector codes
    // ------------------------------------------------------------
    localparam logic [1:0] ACC_SEL_NORMAL = 2'h0;
    localparam logic [1:0] ACC_SEL_SHORTED = 2'h1;
    localparam logic [1:0] ACC_SEL_POS_TEST = 2'h2;
    localparam logic [1:0] ACC_SEL_NEG_TEST = 2'h3;

    // ------------------------------------------------------------
    // bus slave states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_ST_IDLE = 2'b01,
        ACC_ST_ACCESS = 2'b10
    } acc_state_type;

endpackage

`default_nettype wire

/* File: acc_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface acc_reg_if;
    import acc_pkg::*;
    logic wr_en;
    logic [ACC_INDEX_W-1:0] wr_index;
    logic [15:0] wr_data;
    logic [1:0] wr_strb;
    logic [ACC_INDEX_W-1:0] rd_index;
    logic [15:0] rd_data;
    logic rd_hit;

    modport slave (
        output wr_en, wr_index, wr_data, wr_strb, rd_index,
        input rd_data, rd_hit
    );
    modport bank (
        input wr_en, wr_index, wr_data, wr_strb, rd_index,
        output rd_data, rd_hit
    );
endinterface

`default_nettype wire

/* File: acc_apb_slave.sv */
`timescale 1ns/1ps
`default_nettype none

module acc_apb_slave
    import acc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // apb
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ACC_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // register side
    acc_reg_if.slave regs
);

    acc_state_type state_q;
    logic [31:0] prdata_q;
    logic err_q;
    logic done;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign regs.rd_index = paddr_in[ACC_ADDR_W-1:2];
    assign regs.wr_index = paddr_in[ACC_ADDR_W-1:2];
    assign regs.wr_data = pwdata_in[15:0];
    assign regs.wr_strb = pstrb_in[1:0];
    assign done = (state_q == ACC_ST_ACCESS) && psel_in && penable_in;
    assign regs.wr_en = done && pwrite_in && !err_q;
    assign pready_out = (state_q == ACC_ST_ACCESS);
    assign pslverr_out = (state_q == ACC_ST_ACCESS) && err_q;
    assign prdata_out = prdata_q;

    // ------------------------------------------------------------
    // phase tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            state_q <= ACC_ST_IDLE;
        else
            case (state_q)
                ACC_ST_IDLE:
                    if (psel_in && !penable_in)
                        state_q <= ACC_ST_ACCESS;
                ACC_ST_ACCESS:
                    if (done)
                        state_q <= ACC_ST_IDLE;
                default:
                    state_q <= ACC_ST_IDLE;
            endcase
    end

    // ------------------------------------------------------------
    // answer captured in the setup cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end
        else if (state_q == ACC_ST_IDLE && psel_in && !penable_in)
        begin
            err_q <= !regs.rd_hit || (paddr_in[1:0] != 2'h0);
            prdata_q <= (pwrite_in || !regs.rd_hit || paddr_in[1:0] != 2'h0)
                ? 32'h00000000 : {16'h0000, regs.rd_data};
        end
    end

endmodule

`default_nettype wire

/* File: acc_input_decode.sv */
`timescale 1ns/1ps
`default_nettype none

module acc_input_decode
    import acc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // selector
    input wire logic [1:0] select_in,
    // one-hot source enables
    output logic normal_out,
    output logic shorted_out,
    output logic pos_test_out,
    output logic neg_test_out
);

    // ------------------------------------------------------------
    // source switch decode
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            normal_out <= 1'b1;
            shorted_out <= 1'b0;
            pos_test_out <= 1'b0;
            neg_test_out <= 1'b0;
        end
        else
        begin
            normal_out <= (select_in == ACC_SEL_NORMAL);
            shorted_out <= (select_in == ACC_SEL_SHORTED);
            pos_test_out <= (select_in == ACC_SEL_POS_TEST);
            neg_test_out <= (select_in == ACC_SEL_NEG_TEST);
        end
    end

endmodule

`default_nettype wire

/* File: acc_cal_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module acc_cal_regs
    import acc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ACC_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // global filter setting
    input wire logic [3:0] global_dc_filter_setting_in,
    // second channel controls
    output logic [9:0] second_channel_phase_delay_out,
    output logic second_channel_dc_filter_off_out,
    output logic [3:0] second_channel_dc_filter_code_out,
    output logic [1:0] second_channel_input_select_out,
    output logic second_positive_input_on_out,
    output logic second_inputs_shorted_out,
    output logic second_pos_test_on_out,
    output logic second_neg_test_on_out,
    // calibration words
    output logic [23:0] second_channel_offset_out,
    output logic [23:0] second_channel_gain_out,
    output logic [7:0] first_gain_lower_bits_out
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] setup_q;
    logic [15:0] offset_high_q;
    logic [15:0] offset_low_q;
    logic [15:0] gain_high_q;
    logic [15:0] gain_low_q;
    logic [15:0] first_gain_low_q;
    logic [3:0] dc_code_q;
    logic [23:0] offset_q;
    logic [23:0] gain_q;

    acc_reg_if bus_if ();

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16(
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic [1:0] strb,
        input logic [15:0] mask
    );
        logic [15:0] lanes;
        logic [15:0] keep;
        lanes = {{8{strb[1]}}, {8{strb[0]}}};
        keep = lanes & mask;
        merge16 = (old_val & ~keep) | (new_val & keep);
    endfunction

    function automatic logic hit(
        input logic [ACC_INDEX_W-1:0] index,
        input logic [7:0] target
    );
        hit = ({2'h0, index} == target);
    endfunction

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    acc_apb_slave u_apb (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .pstrb_in(pstrb_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .regs(bus_if.slave)
    );

    // ------------------------------------------------------------
    // second channel setup register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            setup_q <= ACC_RST_SETUP;
        else if (bus_if.wr_en && hit(bus_if.wr_index, ACC_IDX_SECOND_SETUP))
            setup_q <= merge16(setup_q, bus_if.wr_data, bus_if.wr_strb,
                ACC_MASK_SETUP);
    end

    // ------------------------------------------------------------
    // second channel offset registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            offset_high_q <= ACC_RST_OFFSET_HIGH;
        else if (bus_if.wr_en
            && hit(bus_if.wr_index, ACC_IDX_SECOND_OFFSET_HIGH))
            offset_high_q <= merge16(offset_high_q, bus_if.wr_data,
                bus_if.wr_strb, ACC_MASK_FULL);
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            offset_low_q <= ACC_RST_OFFSET_LOW;
        else if (bus_if.wr_en
            && hit(bus_if.wr_index, ACC_IDX_SECOND_OFFSET_LOW))
            offset_low_q <= merge16(offset_low_q, bus_if.wr_data,
                bus_if.wr_strb, ACC_MASK_UPPER_BYTE);
    end

    // ------------------------------------------------------------
    // second channel gain registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            gain_high_q <= ACC_RST_GAIN_HIGH;
        else if (bus_if.wr_en
            && hit(bus_if.wr_index, ACC_IDX_SECOND_GAIN_HIGH))
            gain_high_q <= merge16(gain_high_q, bus_if.wr_data,
                bus_if.wr_strb, ACC_MASK_FULL);
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            gain_low_q <= ACC_RST_GAIN_LOW;
        else if (bus_if.wr_en
            && hit(bus_if.wr_index, ACC_IDX_SECOND_GAIN_LOW))
            gain_low_q <= merge16(gain_low_q, bus_if.wr_data,
                bus_if.wr_strb, ACC_MASK_UPPER_BYTE);
    end

    // ------------------------------------------------------------
    // first channel gain low register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            first_gain_low_q <= ACC_RST_FIRST_GAIN_LOW;
        else if (bus_if.wr_en
            && hit(bus_if.wr_index, ACC_IDX_FIRST_GAIN_LOW))
            first_gain_low_q <= merge16(first_gain_low_q, bus_if.wr_data,
                bus_if.wr_strb, ACC_MASK_UPPER_BYTE);
    end

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    always_comb
    begin
        bus_if.rd_hit = 1'b1;
        case ({2'h0, bus_if.rd_index})
            ACC_IDX_FIRST_GAIN_LOW:
                bus_if.rd_data = first_gain_low_q & ACC_MASK_UPPER_BYTE;
            ACC_IDX_SECOND_SETUP:
                bus_if.rd_data = setup_q & ACC_MASK_SETUP;
            ACC_IDX_SECOND_OFFSET_HIGH:
                bus_if.rd_data = offset_high_q;
            ACC_IDX_SECOND_OFFSET_LOW:
                bus_if.rd_data = offset_low_q & ACC_MASK_UPPER_BYTE;
            ACC_IDX_SECOND_GAIN_HIGH:
                bus_if.rd_data = gain_high_q;
            ACC_IDX_SECOND_GAIN_LOW:
                bus_if.rd_data = gain_low_q & ACC_MASK_UPPER_BYTE;
            default:
            begin
                bus_if.rd_data = 16'h0000;
                bus_if.rd_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // dc filter code for the channel
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            dc_code_q <= 4'h0;
        else if (setup_q[ACC_DC_OFF_BIT])
            dc_code_q <= 4'h0;
        else
            dc_code_q <= global_dc_filter_setting_in;
    end

    // ------------------------------------------------------------
    // assembled calibration words
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            offset_q <= {ACC_RST_OFFSET_HIGH, ACC_RST_OFFSET_LOW[15:8]};
            gain_q <= {ACC_RST_GAIN_HIGH, ACC_RST_GAIN_LOW[15:8]};
        end
        else
        begin
            offset_q <= {offset_high_q, offset_low_q[15:8]};
            gain_q <= {gain_high_q, gain_low_q[15:8]};
        end
    end

    // ------------------------------------------------------------
    // input source decode
    // ------------------------------------------------------------
    acc_input_decode u_sel (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .select_in(setup_q[ACC_SEL_MSB:ACC_SEL_LSB]),
        .normal_out(second_positive_input_on_out),
        .shorted_out(second_inputs_shorted_out),
        .pos_test_out(second_pos_test_on_out),
        .neg_test_out(second_neg_test_on_out)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign second_channel_phase_delay_out =
        setup_q[ACC_PHASE_MSB:ACC_PHASE_LSB];
    assign second_channel_dc_filter_off_out = setup_q[ACC_DC_OFF_BIT];
    assign second_channel_dc_filter_code_out = dc_code_q;
    assign second_channel_input_select_out =
        setup_q[ACC_SEL_MSB:ACC_SEL_LSB];
    assign second_channel_offset_out = offset_q;
    assign second_channel_gain_out = gain_q;
    assign first_gain_lower_bits_out = first_gain_low_q[15:8];

endmodule

`default_nettype wire

/* File: acc_cal_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none

module acc_cal_regs_props
    import acc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // apb
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ACC_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // controls
    input wire logic [3:0] global_dc_filter_setting_in,
    input wire logic [9:0] second_channel_phase_delay_out,
    input wire logic second_channel_dc_filter_off_out,
    input wire logic [3:0] second_channel_dc_filter_code_out,
    input wire logic [1:0] second_channel_input_select_out,
    input wire logic second_positive_input_on_out,
    input wire logic second_inputs_shorted_out,
    input wire logic second_pos_test_on_out,
    input wire logic second_neg_test_on_out,
    input wire logic [23:0] second_channel_offset_out,
    input wire logic [23:0] second_channel_gain_out,
    input wire logic [7:0] first_gain_lower_bits_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic done;
    logic rd_done;
    logic wr_all;
    assign done = psel_in && penable_in && pready_out;
    assign rd_done = done && !pwrite_in;
    assign wr_all = done && pwrite_in && pstrb_in[1:0] == 2'h3;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_phase_write:
    assert property (wr_all && paddr_in == 8'h38 |=>
        second_channel_phase_delay_out == $past(pwdata_in[15:6]))
        else $error("phase delay not written");
    a_setup_reserved:
    assert property (rd_done && paddr_in == 8'h38 |-> prdata_out[5:3] == 3'h0)
        else $error("setup reserved bits nonzero");
    a_dc_code_follow:
    assert property (!$past(rst_in) |-> second_channel_dc_filter_code_out ==
        ($past(second_channel_dc_filter_off_out) ? 4'h0
        : $past(global_dc_filter_setting_in)))
        else $error("dc filter code wrong");
    a_select_decode:
    assert property (!$past(rst_in) |-> {second_positive_input_on_out,
        second_inputs_shorted_out, second_pos_test_on_out,
        second_neg_test_on_out} == 4'h8 >> $past(second_channel_input_select_out))
        else $error("input decode wrong");
    a_offset_high:
    assert property (wr_all && paddr_in == 8'h3C |-> ##2
        second_channel_offset_out[23:8] == $past(pwdata_in[15:0], 2))
        else $error("offset upper bits wrong");
    a_offset_low:
    assert property (wr_all && paddr_in == 8'h40 |-> ##2
        second_channel_offset_out[7:0] == $past(pwdata_in[15:8], 2))
        else $error("offset lower bits wrong");
    a_gain_unity:
    assert property ($fell(rst_in) |-> second_channel_gain_out == 24'h800000)
        else $error("gain not unity after reset");
    a_gain_high:
    assert property (wr_all && paddr_in == 8'h44 |-> ##2
        second_channel_gain_out[23:8] == $past(pwdata_in[15:0], 2))
        else $error("gain upper bits wrong");
    a_first_gain:
    assert property (wr_all && paddr_in == 8'h34 |=>
        first_gain_lower_bits_out == $past(pwdata_in[15:8]))
        else $error("first gain bits wrong");
    a_low_bytes_zero:
    assert property (rd_done && (paddr_in == 8'h34 || paddr_in == 8'h40
        || paddr_in == 8'h48) |-> prdata_out[7:0] == 8'h00)
        else $error("reserved low byte nonzero");
    a_error_reads_zero:
    assert property (done && pslverr_out |-> prdata_out == 32'h0)
        else $error("error access returned data");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    c_setup_write: cover property (wr_all && paddr_in == 8'h38);
    c_low_read: cover property (rd_done && paddr_in == 8'h40);
    c_error: cover property (done && pslverr_out);
endmodule

bind acc_cal_regs acc_cal_regs_props u_props (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .global_dc_filter_setting_in(global_dc_filter_setting_in),
    .second_channel_phase_delay_out(second_channel_phase_delay_out),
    .second_channel_dc_filter_off_out(second_channel_dc_filter_off_out),
    .second_channel_dc_filter_code_out(second_channel_dc_filter_code_out),
    .second_channel_input_select_out(second_channel_input_select_out),
    .second_positive_input_on_out(second_positive_input_on_out),
    .second_inputs_shorted_out(second_inputs_shorted_out),
    .second_pos_test_on_out(second_pos_test_on_out),
    .second_neg_test_on_out(second_neg_test_on_out),
    .second_channel_offset_out(second_channel_offset_out),
    .second_channel_gain_out(second_channel_gain_out),
    .first_gain_lower_bits_out(first_gain_lower_bits_out)
);

`default_nettype wire

/* File: acc_testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import acc_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [3:0] pstrb_in = 4'h0;
    logic [3:0] glob_in = 4'h0;
    logic [31:0] prdata;
    logic pready_out;
    logic pslverr;
    logic [9:0] phase;
    logic dc_off;
    logic [3:0] dc_code;
    logic [1:0] sel;
    wire [3:0] dec;
    logic [23:0] offset;
    logic [23:0] gain;
    logic [7:0] fgain;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int check_count = 0;

    always #5 clk_in = ~clk_in;

    acc_cal_regs u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata),
        .pready_out(pready_out), .pslverr_out(pslverr),
        .global_dc_filter_setting_in(glob_in),
        .second_channel_phase_delay_out(phase),
        .second_channel_dc_filter_off_out(dc_off),
        .second_channel_dc_filter_code_out(dc_code),
        .second_channel_input_select_out(sel),
        .second_positive_input_on_out(dec[3]),
        .second_inputs_shorted_out(dec[2]),
        .second_pos_test_on_out(dec[1]),
        .second_neg_test_on_out(dec[0]),
        .second_channel_offset_out(offset),
        .second_channel_gain_out(gain),
        .first_gain_lower_bits_out(fgain)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [15:0] d, input logic [3:0] s);
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= {16'hFFFF, d};
        pstrb_in <= s;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do
            @(posedge clk_in);
        while (pready_out !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 16'h0000, 4'h0);
        chk(rd, exp);
        chk(err, 32'h0);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_chk(8'h34, 32'h0000);
        rd_chk(8'h38, 32'h0000);
        rd_chk(8'h3C, 32'h0000);
        rd_chk(8'h40, 32'h0000);
        rd_chk(8'h44, 32'h8000);
        rd_chk(8'h48, 32'h0000);
        chk(gain, 32'h800000);
        chk(dec, 32'h8);
    endtask

    task automatic t_setup();
        glob_in <= 4'hA;
        apb(1'b1, 8'h38, 16'hFFFF, 4'hF);
        rd_chk(8'h38, 32'hFFC7);
        chk(phase, 32'h3FF);
        chk(dc_off, 32'h1);
        chk(dc_code, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, 8'h38, 16'h8040 | 16'(c), 4'hF);
            settle();
            chk(sel, 32'(c));
            chk(dec, 32'h8 >> c);
            chk(phase, 32'h201);
            chk(dc_code, 32'hA);
        end
    endtask

    task automatic t_cal();
        apb(1'b1, 8'h3C, 16'h8123, 4'hF);
        apb(1'b1, 8'h40, 16'hA5FF, 4'hF);
        apb(1'b1, 8'h44, 16'h1234, 4'hF);
        apb(1'b1, 8'h48, 16'hC3FF, 4'h2);
        apb(1'b1, 8'h34, 16'h5A77, 4'hF);
        settle();
        chk(offset, 32'h8123A5);
        chk(gain, 32'h1234C3);
        chk(fgain, 32'h5A);
        rd_chk(8'h40, 32'hA500);
        rd_chk(8'h48, 32'hC300);
        rd_chk(8'h34, 32'h5A00);
        apb(1'b1, 8'h3C, 16'h0F0F, 4'h1);
        settle();
        chk(offset, 32'h810FA5);
    endtask

    task automatic t_bad();
        apb(1'b1, 8'h00, 16'hFFFF, 4'hF);
        chk(err, 32'h1);
        apb(1'b0, 8'h39, 16'h0000, 4'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h3A, 16'h0000, 4'hF);
        rd_chk(8'h38, 32'h8043);
    endtask

    task automatic t_mid_reset();
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        chk(gain, 32'h800000);
        rd_chk(8'h44, 32'h8000);
        rd_chk(8'h38, 32'h0000);
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_setup();
        t_cal();
        t_bad();
        t_mid_reset();
        wrap_up();
    end

    initial
    begin
        #100000;
        fails++;
        wrap_up();
    end
endmodule

`default_nettype wire
